// ### hdl/pll_divider_spread_regs.v
// serial management slave and pll divider / spread configuration registers
`timescale 1ns/1ps
`include "pll_divider_spread_map.vh"

module pll_divider_spread_regs #(
  parameter [6:0] DEV_ADDR = `SMB_DEV_ADDR
) (
  input  wire        clk,                 // 40 MHz system clock
  input  wire        reset_n,             // asynchronous reset, active low
  input  wire [3:0]  rom_sel,             // frequency table select, applied on the first edge after reset
  input  wire        smb_clk,             // serial management clock
  input  wire        smb_dat_in,          // serial management data, pin level
  output wire        smb_dat_out,         // data output value, always low
  output wire        smb_dat_oe_n,        // low while pulling the data line low
  output reg  [6:0]  cpu_spread_upper,    // processor spread code bits 14..8
  output reg  [14:0] spread_code,         // graphics pll spread code
  output reg  [9:0]  gfx_fb_div,          // applied graphics feedback divider
  output reg  [5:0]  gfx_ref_div,         // applied graphics reference divider
  output reg  [10:0] gfx_vco_mult,        // feedback divider plus eight
  output reg  [6:0]  gfx_vco_div,         // reference divider plus two
  output reg         div_prog_en          // divider programming enable
);

  // ************************************************************
  // serial slave states
  // ************************************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_CMD  = 3'd2;
  localparam [2:0] S_CNT  = 3'd3;
  localparam [2:0] S_WR   = 3'd4;
  localparam [2:0] S_RD   = 3'd5;
  localparam [2:0] S_RACK = 3'd6;

  reg  [2:0]  state_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  ptr_q;
  reg         ack_q;
  reg         drive_q;
  reg         scl_q;
  reg         sda_q;
  reg         load_q;
  reg  [9:0]  fb_div_q;
  reg  [5:0]  ref_div_q;

  wire        scl_rise = smb_clk & ~scl_q;
  wire        scl_fall = ~smb_clk & scl_q;
  wire        start_det = smb_clk & scl_q & sda_q & ~smb_dat_in;
  wire        stop_det = smb_clk & scl_q & ~sda_q & smb_dat_in;
  wire        wr_fire = (state_q == S_WR) & scl_fall & ack_q & ~start_det & ~stop_det;
  wire [7:0]  next_ptr = ptr_q + 8'h01;
  wire [15:0] rom_word;
  wire [7:0]  rd_cur;
  wire [7:0]  rd_next;

  assign smb_dat_out = 1'b0;
  assign smb_dat_oe_n = ~drive_q;

  // ************************************************************
  // read-back decode and power-up table
  // ************************************************************
  function [7:0] rd_data;
    input [7:0] ofs;
    begin
      case (ofs)
        `OFS_DIV_PROG_CTRL:    rd_data = {div_prog_en, 7'h00};
        `OFS_CPU_SPREAD_UPPER: rd_data = {1'b0, cpu_spread_upper};
        `OFS_GFX_DIVIDER_HIGH: rd_data = {fb_div_q[8], fb_div_q[9], ref_div_q};
        `OFS_GFX_FEEDBACK_LOW: rd_data = fb_div_q[7:0];
        `OFS_GFX_SPREAD_LOWER: rd_data = spread_code[7:0];
        `OFS_GFX_SPREAD_UPPER: rd_data = {1'b0, spread_code[14:8]};
        default:               rd_data = 8'h00;
      endcase
    end
  endfunction

  function [15:0] rom_entry;
    input [3:0] sel;
    begin
      case (sel)
        4'h0:    rom_entry = {`ROM_FB_0, `ROM_REF_0};
        4'h1:    rom_entry = {`ROM_FB_1, `ROM_REF_1};
        4'h2:    rom_entry = {`ROM_FB_2, `ROM_REF_2};
        default: rom_entry = {`ROM_FB_3, `ROM_REF_3};
      endcase
    end
  endfunction

  assign rom_word = rom_entry(rom_sel);
  assign rd_cur = rd_data(ptr_q);
  assign rd_next = rd_data(next_ptr);

  // ************************************************************
  // serial management slave
  // ************************************************************
  // pins are taken as synchronous, so one stage of history gives the edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= smb_clk;
      sda_q <= smb_dat_in;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (start_det) begin
      state_q <= S_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (stop_det) begin
      state_q <= S_IDLE;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        S_ADDR, S_CMD, S_CNT, S_WR: begin
          if (scl_rise && !ack_q && bit_q != 4'h8) begin
            shift_q <= {shift_q[6:0], smb_dat_in};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && !ack_q && bit_q == 4'h8) begin
            if (state_q != S_ADDR || shift_q[7:1] == DEV_ADDR) begin
              ack_q <= 1'b1;
              drive_q <= 1'b1;
            end else begin
              state_q <= S_IDLE;
            end
          end else if (scl_fall && ack_q) begin
            ack_q <= 1'b0;
            bit_q <= 4'h0;
            drive_q <= 1'b0;
            case (state_q)
              S_ADDR: begin
                if (shift_q[0]) begin
                  state_q <= S_RD;
                  shift_q <= rd_cur;
                  drive_q <= ~rd_cur[7];
                end else begin
                  state_q <= S_CMD;
                end
              end
              S_CMD: begin
                ptr_q <= shift_q;
                state_q <= S_CNT;
              end
              // byte count is taken but not enforced; bytes run until stop
              S_CNT: state_q <= S_WR;
              default: ptr_q <= next_ptr;
            endcase
          end
        end
        S_RD: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            drive_q <= 1'b0;
            state_q <= S_RACK;
          end else if (scl_fall && bit_q != 4'h0) begin
            shift_q <= {shift_q[6:0], 1'b0};
            drive_q <= ~shift_q[6];
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            if (smb_dat_in) begin
              state_q <= S_IDLE;
            end else begin
              bit_q <= 4'h9;
            end
          end else if (scl_fall && bit_q == 4'h9) begin
            ptr_q <= next_ptr;
            shift_q <= rd_next;
            drive_q <= ~rd_next[7];
            bit_q <= 4'h0;
            state_q <= S_RD;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  // reset takes constants only; the table entry is loaded on the first edge after release
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_q <= 1'b1;
      div_prog_en <= 1'b0;
      cpu_spread_upper <= 7'h00;
      spread_code <= 15'h0000;
      fb_div_q <= 10'h000;
      ref_div_q <= 6'h00;
    end else if (load_q) begin
      load_q <= 1'b0;
      fb_div_q <= rom_word[15:6];
      ref_div_q <= rom_word[5:0];
      spread_code <= `ROM_SPREAD;
    end else if (wr_fire) begin
      case (ptr_q)
        `OFS_DIV_PROG_CTRL:    div_prog_en <= shift_q[`BIT_DIV_PROG_EN];
        `OFS_CPU_SPREAD_UPPER: cpu_spread_upper <= shift_q[6:0];
        `OFS_GFX_DIVIDER_HIGH: begin
          fb_div_q[8] <= shift_q[`BIT_FB_DIV8];
          fb_div_q[9] <= shift_q[`BIT_FB_DIV9];
          ref_div_q <= shift_q[`REF_DIV_MSB:0];
        end
        `OFS_GFX_FEEDBACK_LOW: fb_div_q[7:0] <= shift_q;
        `OFS_GFX_SPREAD_LOWER: spread_code[7:0] <= shift_q;
        `OFS_GFX_SPREAD_UPPER: spread_code[14:8] <= shift_q[6:0];
        default: load_q <= 1'b0;
      endcase
    end
  end

  // ************************************************************
  // applied dividers and vco ratio
  // ************************************************************
  // the pll only sees divider edits while programming is enabled, so a half-written
  // pair of bytes never reaches it when the host clears the enable first
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gfx_fb_div <= 10'h000;
      gfx_ref_div <= 6'h00;
      gfx_vco_mult <= `FB_DIV_ADD;
      gfx_vco_div <= `REF_DIV_ADD;
    end else begin
      if (load_q) begin
        gfx_fb_div <= rom_word[15:6];
        gfx_ref_div <= rom_word[5:0];
      end else if (div_prog_en) begin
        gfx_fb_div <= fb_div_q;
        gfx_ref_div <= ref_div_q;
      end
      gfx_vco_mult <= {1'b0, gfx_fb_div} + `FB_DIV_ADD;
      gfx_vco_div <= {1'b0, gfx_ref_div} + `REF_DIV_ADD;
    end
  end

endmodule // pll_divider_spread_regs

// ### inc/pll_divider_spread_map.vh
// register offsets, field positions and table values for the pll divider and spread slice
`ifndef PLL_DIVIDER_SPREAD_MAP_VH
`define PLL_DIVIDER_SPREAD_MAP_VH

// ************************************************************
// register offsets (serial management command codes)
// ************************************************************
`define OFS_DIV_PROG_CTRL      8'h0A
`define OFS_CPU_SPREAD_UPPER   8'h0E
`define OFS_GFX_DIVIDER_HIGH   8'h0F
`define OFS_GFX_FEEDBACK_LOW   8'h10
`define OFS_GFX_SPREAD_LOWER   8'h11
`define OFS_GFX_SPREAD_UPPER   8'h12

// ************************************************************
// field positions
// ************************************************************
`define BIT_DIV_PROG_EN        7
`define BIT_FB_DIV8            7
`define BIT_FB_DIV9            6
`define REF_DIV_MSB            5

// ************************************************************
// vco arithmetic offsets
// ************************************************************
`define FB_DIV_ADD             11'h008
`define REF_DIV_ADD            7'h02

// ************************************************************
// serial interface and power-up table
// ************************************************************
// arbitrary default slave address
`define SMB_DEV_ADDR           7'h69
`define ROM_FB_0               10'h0C0
`define ROM_REF_0              6'h0C
`define ROM_FB_1               10'h0C8
`define ROM_REF_1              6'h0C
`define ROM_FB_2               10'h0D0
`define ROM_REF_2              6'h0D
`define ROM_FB_3               10'h0D8
`define ROM_REF_3              6'h0D
`define ROM_SPREAD             15'h0000

`endif

// ### sim/pll_divider_spread_asserts.sv
// checker for the divider and spread register slice
`timescale 1ns/1ps
`include "pll_divider_spread_map.vh"
module pll_divider_spread_asserts (
  input wire        clk,
  input wire        reset_n,
  input wire [3:0]  rom_sel,
  input wire        smb_clk,
  input wire        smb_dat_in,
  input wire        smb_dat_out,
  input wire        smb_dat_oe_n,
  input wire [6:0]  cpu_spread_upper,
  input wire [14:0] spread_code,
  input wire [9:0]  gfx_fb_div,
  input wire [5:0]  gfx_ref_div,
  input wire [10:0] gfx_vco_mult,
  input wire [6:0]  gfx_vco_div,
  input wire        div_prog_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [9:0] rfb = rom_sel == 4'h0 ? `ROM_FB_0 : rom_sel == 4'h1 ? `ROM_FB_1 :
                   rom_sel == 4'h2 ? `ROM_FB_2 : `ROM_FB_3;
  wire [5:0] rrf = rom_sel < 4'h2 ? `ROM_REF_0 : `ROM_REF_2;
  property p_mult;
    $past(reset_n) |-> gfx_vco_mult == $past(gfx_fb_div) + `FB_DIV_ADD;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier is not divider plus 8");
  property p_div;
    $past(reset_n) |-> gfx_vco_div == $past(gfx_ref_div) + `REF_DIV_ADD;
  endproperty
  a_div: assert property (p_div) else $error("divisor is not divider plus 2");
  property p_fbh;
    $past(reset_n) && !div_prog_en |=> $stable(gfx_fb_div);
  endproperty
  a_fbh: assert property (p_fbh) else $error("feedback moved while disabled");
  property p_rfh;
    $past(reset_n) && !div_prog_en |=> $stable(gfx_ref_div);
  endproperty
  a_rfh: assert property (p_rfh) else $error("reference moved while disabled");
  property p_romf;
    !$past(reset_n) |=> gfx_fb_div == $past(rfb);
  endproperty
  a_romf: assert property (p_romf) else $error("feedback not loaded from table");
  property p_romr;
    !$past(reset_n) |=> gfx_ref_div == $past(rrf) && spread_code == 15'h0000;
  endproperty
  a_romr: assert property (p_romr) else $error("reference not loaded from table");
  property p_sda;
    $changed(smb_dat_oe_n) |-> !smb_clk;
  endproperty
  a_sda: assert property (p_sda) else $error("data changed with clock high");
  property p_out;
    smb_dat_out == 1'b0;
  endproperty
  a_out: assert property (p_out) else $error("data output not low");
  c_en: cover property ($rose(div_prog_en));
  c_ack: cover property ($fell(smb_dat_oe_n));
  c_fb: cover property ($past(reset_n) && $changed(gfx_fb_div));
endmodule // pll_divider_spread_asserts
bind pll_divider_spread_regs pll_divider_spread_asserts chk_i (
  .clk(clk), .reset_n(reset_n), .rom_sel(rom_sel), .smb_clk(smb_clk),
  .smb_dat_in(smb_dat_in), .smb_dat_out(smb_dat_out), .smb_dat_oe_n(smb_dat_oe_n),
  .cpu_spread_upper(cpu_spread_upper), .spread_code(spread_code), .gfx_fb_div(gfx_fb_div),
  .gfx_ref_div(gfx_ref_div), .gfx_vco_mult(gfx_vco_mult), .gfx_vco_div(gfx_vco_div),
  .div_prog_en(div_prog_en));

// ### sim/smb_host.sv
// serial management host model for the divider and spread registers
`timescale 1ns/1ps
module smb_host (
  input  wire clk,     // system clock
  input  wire sda,     // resolved data line
  output reg  scl,     // serial clock
  output reg  sda_drv  // 0 pulls data low
);
  integer   hp  = 4;     // clocks per phase; raised to act as a slow host
  reg [6:0] dev = 7'h69;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task ph;
    repeat (hp) @(negedge clk);
  endtask
  // data only moves while the clock is low
  task bt(input b, output r);
    begin
      ph;
      sda_drv = b;
      ph;
      scl = 1'b1;
      ph;
      r = sda;
      scl = 1'b0;
    end
  endtask
  task xb(input [7:0] d, input m, output [7:0] r, output a);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bt(d[i], r[i]);
      bt(m, a);
    end
  endtask
  task st;
    begin
      ph;
      sda_drv = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      sda_drv = 1'b0;
      ph;
      scl = 1'b0;
    end
  endtask
  task sp;
    begin
      ph;
      sda_drv = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      sda_drv = 1'b1;
    end
  endtask
  task wr(input [7:0] o, input [7:0] d, output ok);
    reg [7:0] r;
    reg [3:0] a;
    begin
      st;
      xb({dev, 1'b0}, 1'b1, r, a[0]);
      xb(o, 1'b1, r, a[1]);
      xb(8'h01, 1'b1, r, a[2]);
      xb(d, 1'b1, r, a[3]);
      sp;
      ok = (a == 4'h0);
    end
  endtask
  task rd(input [7:0] o, output [7:0] d, output ok);
    reg [7:0] r;
    reg [4:0] a;
    begin
      st;
      xb({dev, 1'b0}, 1'b1, r, a[0]);
      xb(o, 1'b1, r, a[1]);
      xb(8'h01, 1'b1, r, a[2]);
      st;
      xb({dev, 1'b1}, 1'b1, r, a[3]);
      xb(8'hFF, 1'b1, d, a[4]);
      sp;
      ok = (a[3:0] == 4'h0);
    end
  endtask
endmodule // smb_host

// ### sim/tb.sv
// self-checking bench for the divider and spread register slice
`timescale 1ns/1ps
`include "pll_divider_spread_map.vh"
module tb;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [3:0]  rom_sel = 4'h0;
  wire        scl, sda_drv, dat_out, oe_n, en;
  wire        sda = sda_drv & (oe_n | dat_out); // pulled up when nobody drives
  wire [6:0]  cup, gdv;
  wire [14:0] sc;
  wire [9:0]  fb;
  wire [5:0]  rf;
  wire [10:0] gm;
  integer     mismatches = 0, checked = 0, seed = 32'hdf8824df, k;
  reg  [7:0]  v, w;
  reg  [9:0]  f;
  reg  [5:0]  r;
  reg         ok;
  pll_divider_spread_regs pll_divider_spread_regs_i (.clk(clk), .reset_n(reset_n),
    .rom_sel(rom_sel), .smb_clk(scl), .smb_dat_in(sda), .smb_dat_out(dat_out),
    .smb_dat_oe_n(oe_n), .cpu_spread_upper(cup), .spread_code(sc), .gfx_fb_div(fb),
    .gfx_ref_div(rf), .gfx_vco_mult(gm), .gfx_vco_div(gdv), .div_prog_en(en));
  smb_host smb_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  initial forever #12.5 clk = ~clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [7:0] o, input [7:0] d);
    begin
      smb_host_i.wr(o, d, ok);
      chk({15'h0, ok}, 16'h0001);
    end
  endtask
  task rchk(input [7:0] o, input [7:0] e);
    begin
      smb_host_i.rd(o, v, ok);
      chk({ok, v}, {8'h01, e});
    end
  endtask
  function [7:0] b15(input [9:0] n, input [5:0] m);
    b15 = {n[8], n[9], m};
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  initial begin
    rom_sel = $random(seed);
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    f = rom_sel == 4'h0 ? `ROM_FB_0 : rom_sel == 4'h1 ? `ROM_FB_1 :
        rom_sel == 4'h2 ? `ROM_FB_2 : `ROM_FB_3;
    r = rom_sel < 4'h2 ? `ROM_REF_0 : `ROM_REF_2;
    chk({fb, rf}, {f, r});
    rchk(`OFS_GFX_DIVIDER_HIGH, b15(f, r));
    rchk(`OFS_GFX_FEEDBACK_LOW, f[7:0]);
    wreg(`OFS_CPU_SPREAD_UPPER, 8'hFF);
    chk(cup, 7'h7F);
    rchk(`OFS_CPU_SPREAD_UPPER, 8'h7F);
    rchk(8'h13, 8'h00);
    smb_host_i.dev = 7'h11;
    smb_host_i.wr(`OFS_CPU_SPREAD_UPPER, 8'h00, ok);
    chk({15'h0, ok}, 16'h0000);
    smb_host_i.dev = 7'h69;
    rchk(`OFS_CPU_SPREAD_UPPER, 8'h7F);
    $display("test access done");
    // a fixed 00/FF pair, then three random pairs, stand in for entries of the vendor spread table
    for (k = 0; k < 4; k = k + 1) begin
      v = k == 0 ? 8'h00 : $random(seed);
      w = k == 0 ? 8'hFF : $random(seed);
      wreg(`OFS_GFX_SPREAD_LOWER, v);
      wreg(`OFS_GFX_SPREAD_UPPER, w);
      chk(sc, {w[6:0], v});
      rchk(`OFS_GFX_SPREAD_UPPER, {1'b0, w[6:0]});
    end
    $display("test spread done");
    for (k = 0; k < 2; k = k + 1) begin
      smb_host_i.hp = 4 + 3 * k;
      w = {fb[8], fb[9], rf};
      f = $random(seed);
      r = $random(seed);
      wreg(`OFS_GFX_DIVIDER_HIGH, b15(f, r));
      wreg(`OFS_GFX_FEEDBACK_LOW, f[7:0]);
      chk(b15(fb, rf), w);
      rchk(`OFS_GFX_DIVIDER_HIGH, b15(f, r));
      wreg(`OFS_DIV_PROG_CTRL, 8'h80);
      repeat (3) @(negedge clk);
      chk({fb, rf}, {f, r});
      chk({5'h00, gm}, {5'h00, {1'b0, f} + 11'h008});
      chk({9'h000, gdv}, {9'h000, {1'b0, r} + 7'h02});
      wreg(`OFS_DIV_PROG_CTRL, 8'h7F);
      rchk(`OFS_DIV_PROG_CTRL, 8'h00);
    end
    $display("test divider done");
    tally_and_finish;
  end
endmodule // tb
